/* swdt_pkg.sv */
/*
  constants, register map and carrier types for the smbus watchdog.
  assumes a 50 mhz system clock.
*/
package swdt_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int PW_1MS_US = 1000;
  localparam int PW_20MS_US = 20000;
  localparam int PW_100MS_US = 100000;
  localparam int PW_4S_US = 4000000;
  localparam int PW_1MS_CYC = PW_1MS_US * 1000 / CLK_NS;
  localparam int PW_20MS_CYC = PW_20MS_US * 1000 / CLK_NS;
  localparam int PW_100MS_CYC = PW_100MS_US * 1000 / CLK_NS;
  localparam int PW_4S_CYC = PW_4S_US / CLK_NS * 1000;
  localparam int SEC_PER_MIN = 60;
  // ----------------------------------------------------------------
  // smbus addressing and map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_WEAK = 7'h4e; // 8-bit 0x9c
  localparam logic [6:0] ADDR_STRONG = 7'h37; // 8-bit 0x6e
  localparam logic [7:0] IDX_PIN_FUNC = 8'h03;
  localparam logic [7:0] IDX_WD_CTRL = 8'h36;
  localparam logic [7:0] IDX_WD_COUNT = 8'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PINF_RESET = 8'h00;
  // control field positions
  localparam int CB_RSVD = 7;
  localparam int CB_FLAG = 6;
  localparam int CB_EN = 5;
  localparam int CB_STYLE = 4;
  localparam int CB_UNIT = 3;
  localparam int CB_POL = 2;
  localparam int CB_PW_HI = 1;
  localparam int CB_PW_LO = 0;
  localparam int PF_HI = 1;
  localparam int PF_LO = 0;
  localparam logic [1:0] PF_GPIO = 2'h0;
  localparam logic [1:0] PF_LAMP = 2'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_CMD = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } swdt_bus_e;

  typedef struct packed {
    logic [7:0] pin_function_select_a;
    logic [7:0] watchdog_control;
    logic [7:0] watchdog_timeout_count;
  } swdt_regs_s;
endpackage

/* swdt_top.sv */
/*
  smbus watchdog: smbus byte-data slave, three registers, a
  second/minute watchdog and its expiry output on a shared pin.
  assumes scl/sda arrive asynchronously, open drain, and that the
  bus clock is much slower than mclk.
*/
`timescale 1ns/10ps
// Function
// - expiry sets timeout_flag; writing one clears it, zero leaves it
// - enabled timer times timeout_count units, 1 to 255; a count of 0 times one unit
// - output_style 0 holds a level, 1 gives one pulse
// - time_unit_select 0 counts seconds, 1 counts minutes
// - output_polarity 1 asserts high, 0 asserts low
// - pulse length select: 1 ms, 20 ms, 100 ms or 4 s
// - control bit 7 reads zero, writes ignored
// - pin function 00 gpio, 01 lamp, 10/11 expiry output
// - smbus address 0x9c with weak strap, 0x6e with strong pull-up
// - control and count reset to zero, timer disabled
// - control and count are read/write standby registers
module swdt_top import swdt_pkg::*; #(
  parameter int TICK_CYC = CLK_HZ,
  parameter int PW_LONG_CYC = PW_4S_CYC
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_STRAP,
  input wire logic GPIO_OUT_DATA,
  input wire logic LAMP_DATA,
  output logic MULTI_PIN,
  output logic EXPIRY_OUTPUT,
  output logic TIMEOUT_FLAG
);
  if (TICK_CYC < 2 || PW_LONG_CYC < 2) begin : g_bad_counts
    $error("swdt_top: counts too small");
  end
  // strap synchroniser refills for two edges after reset
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] strap_s;
    logic scl_d;
    logic sda_d;
    logic [6:0] my_addr;
    logic [1:0] strap_wait;
    swdt_bus_e bst;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic ack;
    logic sda_drv;
    logic [7:0] idx;
    swdt_regs_s regs;
    logic [31:0] tick;
    logic [5:0] subcnt;
    logic [7:0] remain;
    logic asserted;
    logic [31:0] pcnt;
    logic pulsed;
  } swdt_state_s;

  swdt_state_s s_r, s_nxt;

  logic scl_rise, scl_fall, start_c, stop_c, sda_v, scl_v;
  logic [7:0] ctrl, rdata;
  logic [31:0] pw_cyc;
  logic unit_end, expire, cnt_wr, ctrl_wr, pw_done;
  logic [7:0] wval;

  assign ctrl = s_r.regs.watchdog_control;
  assign scl_v = s_r.scl_s[1];
  assign sda_v = s_r.sda_s[1];
  assign scl_rise = scl_v && !s_r.scl_d;
  assign scl_fall = !scl_v && s_r.scl_d;
  assign start_c = scl_v && s_r.scl_d && s_r.sda_d && !sda_v;
  assign stop_c = scl_v && s_r.scl_d && !s_r.sda_d && sda_v;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (s_r.idx)
      IDX_PIN_FUNC: rdata = s_r.regs.pin_function_select_a;
      IDX_WD_CTRL: rdata = {1'b0, ctrl[6:0]};
      IDX_WD_COUNT: rdata = s_r.regs.watchdog_timeout_count;
      default: rdata = 8'h00;
    endcase
  end

  always_comb begin
    case (ctrl[CB_PW_HI:CB_PW_LO])
      2'h0: pw_cyc = PW_1MS_CYC;
      2'h1: pw_cyc = PW_20MS_CYC;
      2'h2: pw_cyc = PW_100MS_CYC;
      default: pw_cyc = PW_LONG_CYC;
    endcase
  end

  assign wval = {s_r.sh[6:0], sda_v};
  // a write commits at the eighth rising edge of the data byte
  assign cnt_wr = scl_rise && s_r.bst == ST_WDATA && s_r.bitn == 4'h7
    && s_r.idx == IDX_WD_COUNT;
  assign ctrl_wr = scl_rise && s_r.bst == ST_WDATA && s_r.bitn == 4'h7
    && s_r.idx == IDX_WD_CTRL;
  assign unit_end = s_r.tick == 32'(TICK_CYC - 1)
    && (!ctrl[CB_UNIT] || s_r.subcnt == 6'(SEC_PER_MIN - 1));
  assign expire = ctrl[CB_EN] && !s_r.asserted && unit_end
    && s_r.remain <= 8'h01;
  // pcnt runs 0 to pw_cyc - 1 while active: exactly pw_cyc cycles
  assign pw_done = s_r.pcnt >= pw_cyc;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s = {s_r.scl_s[0], SCL};
    s_nxt.sda_s = {s_r.sda_s[0], SDA_IN};
    s_nxt.strap_s = {s_r.strap_s[0], ADDR_STRAP};
    s_nxt.scl_d = scl_v;
    s_nxt.sda_d = sda_v;
    // strap caught once, only after its synchroniser holds the pin level
    if (s_r.strap_wait != STRAP_DONE) begin
      s_nxt.strap_wait = s_r.strap_wait + 2'h1;
      if (s_r.strap_wait == STRAP_SETTLE)
        s_nxt.my_addr = s_r.strap_s[1] ? ADDR_STRONG : ADDR_WEAK;
    end

    // smbus byte-data slave
    if (start_c) begin
      s_nxt.bst = ST_ADDR;
      s_nxt.bitn = 4'h0;
      s_nxt.sda_drv = 1'b0;
    end else if (stop_c) begin
      s_nxt.bst = ST_IDLE;
      s_nxt.sda_drv = 1'b0;
    end else if (s_r.bst != ST_IDLE) begin
      if (scl_rise && s_r.bitn < 4'h8) begin
        s_nxt.sh = wval;
        s_nxt.bitn = s_r.bitn + 4'h1;
      end
      if (scl_fall) begin
        s_nxt.sda_drv = 1'b0;
        if (s_r.bitn == 4'h8) begin
          // ack slot begins
          case (s_r.bst)
            ST_ADDR: s_nxt.ack = s_r.sh[7:1] == s_r.my_addr;
            ST_RDATA: s_nxt.ack = 1'b0;
            default: s_nxt.ack = 1'b1;
          endcase
          s_nxt.sda_drv = s_r.bst == ST_ADDR ? s_r.sh[7:1] == s_r.my_addr
            : s_r.bst != ST_RDATA;
          s_nxt.rd = s_r.bst == ST_ADDR ? s_r.sh[0] : s_r.rd;
          s_nxt.bitn = 4'h9;
        end else if (s_r.bitn == 4'h9) begin
          s_nxt.bitn = 4'h0;
          case (s_r.bst)
            ST_ADDR: begin
              if (!s_r.ack)
                s_nxt.bst = ST_IDLE;
              else if (s_r.rd) begin
                s_nxt.bst = ST_RDATA;
                s_nxt.sh = rdata;
                s_nxt.sda_drv = !rdata[7];
              end else
                s_nxt.bst = ST_CMD;
            end
            ST_CMD: begin
              s_nxt.idx = s_r.sh;
              s_nxt.bst = ST_WDATA;
            end
            ST_WDATA: s_nxt.bst = ST_WDATA;
            default: s_nxt.bst = ST_IDLE;
          endcase
        end else if (s_r.bst == ST_RDATA) begin
          s_nxt.sda_drv = !s_r.sh[7];
        end
      end
      if (s_r.bst == ST_RDATA && scl_rise && s_r.bitn < 4'h8)
        s_nxt.sh = {s_r.sh[6:0], 1'b0};
    end

    // register writes
    if (scl_rise && s_r.bst == ST_WDATA && s_r.bitn == 4'h7) begin
      case (s_r.idx)
        IDX_PIN_FUNC: s_nxt.regs.pin_function_select_a = wval;
        IDX_WD_CTRL: begin
          s_nxt.regs.watchdog_control = {1'b0, ctrl[CB_FLAG],
            wval[5:0]};
          if (wval[CB_FLAG])
            s_nxt.regs.watchdog_control[CB_FLAG] = 1'b0;
        end
        IDX_WD_COUNT: s_nxt.regs.watchdog_timeout_count = wval;
        default: s_nxt.idx = s_r.idx;
      endcase
    end

    // ----------------------------------------------------------------
    // timer
    // ----------------------------------------------------------------
    if (!ctrl[CB_EN] || cnt_wr || (ctrl_wr && !ctrl[CB_EN])) begin
      // reload on enable edge or count write
      s_nxt.tick = 32'h0;
      s_nxt.subcnt = 6'h0;
      s_nxt.remain = cnt_wr ? wval : s_r.regs.watchdog_timeout_count;
      if (cnt_wr || !ctrl[CB_EN])
        s_nxt.asserted = 1'b0;
    end else if (!s_r.asserted) begin
      if (s_r.tick == 32'(TICK_CYC - 1)) begin
        s_nxt.tick = 32'h0;
        s_nxt.subcnt = (unit_end || !ctrl[CB_UNIT]) ? 6'h0
          : s_r.subcnt + 6'h1;
        if (unit_end && s_r.remain != 8'h0)
          s_nxt.remain = s_r.remain - 8'h1;
      end else
        s_nxt.tick = s_r.tick + 32'h1;
      // zero count expires at the first unit boundary
      if (expire) begin
        s_nxt.asserted = 1'b1;
        s_nxt.pcnt = 32'h0;
        s_nxt.pulsed = 1'b0;
      end
    end else if (ctrl[CB_STYLE]) begin
      // latch the end so a wider width chosen later cannot re-open it
      if (pw_done)
        s_nxt.pulsed = 1'b1;
      else
        s_nxt.pcnt = s_r.pcnt + 32'h1;
    end

    // set wins over the clear
    if (expire)
      s_nxt.regs.watchdog_control[CB_FLAG] = 1'b1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      s_r <= '0;
      s_r.scl_s <= 2'h3;
      s_r.sda_s <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.bst <= ST_IDLE;
      s_r.my_addr <= ADDR_WEAK;
      s_r.regs.watchdog_control <= CTRL_RESET;
      s_r.regs.watchdog_timeout_count <= COUNT_RESET;
      s_r.regs.pin_function_select_a <= PINF_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic active;
  // pulse mode: active only while the width counter runs
  assign active = s_r.asserted
    && (!ctrl[CB_STYLE] || (!s_r.pulsed && !pw_done));
  assign EXPIRY_OUTPUT = ctrl[CB_POL] ? active : !active;
  assign TIMEOUT_FLAG = ctrl[CB_FLAG];
  assign SDA_OUT = 1'b0;
  assign SDA_OE = s_r.sda_drv;

  always_comb begin
    case (s_r.regs.pin_function_select_a[PF_HI:PF_LO])
      PF_GPIO: MULTI_PIN = GPIO_OUT_DATA;
      PF_LAMP: MULTI_PIN = LAMP_DATA;
      default: MULTI_PIN = EXPIRY_OUTPUT;
    endcase
  end
endmodule // swdt_top

/* swdt_host.sv */
/*
  smbus host model: byte-data write, and read with repeated start.
  assumes open-drain sda with pull-up; scl stands high between frames.
*/
`timescale 1ns/10ps
module swdt_host import swdt_pkg::*; (
  input wire logic mclk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  assign sda = drv & ~sda_oe;
  // each phase is a quarter of the 160 ns bit
  task automatic ph(input logic c, input logic d);
    scl <= c;
    drv <= d;
    repeat (2) @(posedge mclk);
  endtask
  // sda only moves with scl low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, drv);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda;
    ph(1'b1, b);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  // start is cond(1,0), stop is cond(0,1)
  task automatic cond(input logic a, input logic b);
    ph(1'b0, drv);
    ph(1'b0, a);
    ph(1'b1, a);
    ph(1'b1, a);
    ph(1'b1, b);
    ph(1'b1, b);
  endtask
  task automatic xfer(input logic [6:0] a, input logic [7:0] idx, d,
                      input logic rd, output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic k0, k1, k2;
    cond(1'b1, 1'b0);
    byte_io({a, 1'b0}, x, k0);
    byte_io(idx, x, k1);
    if (rd) begin
      cond(1'b1, 1'b0);
      byte_io({a, 1'b1}, x, k2);
      byte_io(8'hff, q, x[0]);
    end else begin
      byte_io(d, x, k2);
    end
    cond(1'b0, 1'b1);
    ok = k0 & k1 & k2;
  endtask
endmodule // swdt_host

/* swdt_top_chk.sv */
/*
  port assertions for swdt_top.
  assumes one clock and the async active-high reset.
*/
`timescale 1ns/10ps
module swdt_chk import swdt_pkg::*; #(
  parameter int TICK_CYC = 50,
  parameter int PW_LONG_CYC = 100
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic ADDR_STRAP,
  input wire logic GPIO_OUT_DATA,
  input wire logic LAMP_DATA,
  input wire logic MULTI_PIN,
  input wire logic EXPIRY_OUTPUT,
  input wire logic TIMEOUT_FLAG
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  sequence s_fire;
    $rose(TIMEOUT_FLAG) ##0 $changed(EXPIRY_OUTPUT);
  endsequence
  property p_fire;
    $rose(TIMEOUT_FLAG) |-> s_fire;
  endproperty
  a_fire: assert property (p_fire) else $error("flag without output");
  // shortest pulse is far longer than eight cycles
  property p_hold;
    s_fire |=> $stable(EXPIRY_OUTPUT) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("output too short");
  property p_rst;
    $fell(RST) |-> EXPIRY_OUTPUT && !TIMEOUT_FLAG && !SDA_OE;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_od;
    SDA_OUT == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_oe_scl;
    $changed(SDA_OE) |-> !SCL;
  endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
  property p_oe_len;
    $rose(SDA_OE) |=> SDA_OE [*3];
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("sda glitch");
  // with all three sources equal every pin function must show that level
  property p_pin;
    GPIO_OUT_DATA == LAMP_DATA && LAMP_DATA == EXPIRY_OUTPUT
      |-> MULTI_PIN == EXPIRY_OUTPUT;
  endproperty
  a_pin: assert property (p_pin) else $error("pin source bad");
  // a clear only lands just after scl rose on the data byte
  property p_clr;
    $fell(TIMEOUT_FLAG) |-> $past(SCL, 2) || $past(SCL, 4) || $past(SCL, 6);
  endproperty
  a_clr: assert property (p_clr) else $error("flag fell off bus");
endmodule // swdt_chk

bind swdt_top swdt_chk #(.TICK_CYC(TICK_CYC), .PW_LONG_CYC(PW_LONG_CYC))
  i_swdt_chk (.MCLK(MCLK), .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_STRAP(ADDR_STRAP),
  .GPIO_OUT_DATA(GPIO_OUT_DATA), .LAMP_DATA(LAMP_DATA),
  .MULTI_PIN(MULTI_PIN), .EXPIRY_OUTPUT(EXPIRY_OUTPUT),
  .TIMEOUT_FLAG(TIMEOUT_FLAG));

/* swdt_top_tb_top.sv */
/*
  self-checking bench for swdt_top, short tick and short long-pulse width.
  assumes swdt_host and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module swdt_top_tb_top import swdt_pkg::*;;
  localparam int TK = 50;
  localparam int PL = 100;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic gpio_d = 1'b0;
  logic lamp_d = 1'b0;
  logic [6:0] dev = ADDR_WEAK;
  logic scl, sda, sda_oe, pin, expo, flag;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 mclk = ~mclk;
  swdt_top #(.TICK_CYC(TK), .PW_LONG_CYC(PL)) i_swdt_top (
    .MCLK(mclk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(sda_oe), .ADDR_STRAP(strap), .GPIO_OUT_DATA(gpio_d),
    .LAMP_DATA(lamp_d), .MULTI_PIN(pin), .EXPIRY_OUTPUT(expo),
    .TIMEOUT_FLAG(flag));
  swdt_host i_swdt_host (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic chk(input logic [15:0] got, lo, hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %h not %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] idx, d);
    logic [7:0] q;
    logic ok;
    i_swdt_host.xfer(dev, idx, d, 1'b0, q, ok);
    chk({15'h0, ok}, 16'h1, 16'h1);
  endtask
  task automatic rd(input logic [7:0] idx, e);
    logic [7:0] q;
    logic ok;
    i_swdt_host.xfer(dev, idx, 8'h00, 1'b1, q, ok);
    chk({7'h0, ok, q}, {8'h1, e}, {8'h1, e});
  endtask
  task automatic wait_out(input logic v, output int n);
    n = 0;
    while (expo !== v && n < 60000) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic s_regs();
    logic [7:0] q;
    logic ok;
    rd(IDX_WD_CTRL, 8'h00);
    rd(IDX_WD_COUNT, 8'h00);
    wr(IDX_WD_CTRL, 8'h8c);
    rd(IDX_WD_CTRL, 8'h0c);
    wr(IDX_WD_COUNT, 8'hff);
    i_swdt_host.xfer(ADDR_STRONG, IDX_WD_COUNT, 8'h00, 1'b0, q, ok);
    chk({15'h0, ok}, 16'h0, 16'h0);
    rd(IDX_WD_COUNT, 8'hff);
    wr(8'h50, 8'h5a);
    rd(8'h50, 8'h00);
  endtask
  // polarity high and disabled, so the expiry source sits at 0
  task automatic s_pin();
    logic [1:0] q;
    logic [1:0] e;
    for (int p = 0; p < 4; p++) begin
      wr(IDX_PIN_FUNC, 8'(p));
      gpio_d <= 1'b1;
      lamp_d <= 1'b0;
      repeat (2) @(posedge mclk);
      q[1] = pin;
      gpio_d <= 1'b0;
      lamp_d <= 1'b1;
      repeat (2) @(posedge mclk);
      q[0] = pin;
      e = p == 0 ? 2'h2 : p == 1 ? 2'h1 : 2'h0;
      chk({14'h0, q}, {14'h0, e}, {14'h0, e});
    end
  endtask
  // about 20 cycles pass between commit and the end of a write
  task automatic s_timer();
    int n;
    wr(IDX_WD_COUNT, 8'h08);
    wr(IDX_WD_CTRL, 8'h24);
    wr(IDX_WD_COUNT, 8'h08);
    wait_out(1'b1, n);
    chk(16'(n), 16'(8 * TK - 30), 16'(8 * TK - 10));
    chk({14'h0, pin, flag}, 16'h3, 16'h3);
    wr(IDX_WD_CTRL, 8'h24);
    rd(IDX_WD_CTRL, 8'h64);
    wr(IDX_WD_CTRL, 8'h44);
    rd(IDX_WD_CTRL, 8'h04);
    chk({14'h0, expo, flag}, 16'h0, 16'h0);
    wr(IDX_WD_COUNT, 8'h01);
    wr(IDX_WD_CTRL, 8'h3b);
    wait_out(1'b0, n);
    chk(16'(n), 16'(60 * TK - 30), 16'(60 * TK - 10));
    wait_out(1'b1, n);
    chk(16'(n), 16'(PL), 16'(PL));
    // shortest width, polarity high, one second
    wr(IDX_WD_CTRL, 8'h14);
    wr(IDX_WD_CTRL, 8'h34);
    wait_out(1'b1, n);
    chk(16'(n), 16'(TK - 30), 16'(TK - 10));
    wait_out(1'b0, n);
    chk(16'(n), 16'(PW_1MS_CYC), 16'(PW_1MS_CYC));
  endtask
  task automatic s_strap();
    rst <= 1'b1;
    strap <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    dev = ADDR_STRONG;
    rd(IDX_WD_CTRL, 8'h00);
    chk({14'h0, expo, flag}, 16'h2, 16'h2);
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    s_regs();
    s_pin();
    s_timer();
    s_strap();
    close_out();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      close_out();
    end
  end
endmodule // swdt_top_tb_top
